// ---- verilog/bce_defines.svh ----
// Register offsets, field positions and reset values of the cipher engine front end
`ifndef BCE_DEFINES_SVH
`define BCE_DEFINES_SVH
`define BCE_A_CONL 8'h00
`define BCE_A_CONH 8'h01
`define BCE_A_STAT 8'h02
`define BCE_A_OTP 8'h03
`define BCE_A_TXTA 5'h02
`define BCE_A_TXTB 5'h03
`define BCE_A_TXTC 5'h04
`define BCE_A_KEY 4'h3
`define BCE_B_ON 15
`define BCE_B_OPERATION_DONE_IRQ_ENABLE 11
`define BCE_B_BUFFER_FREE_IRQ_ENABLE 10
`define BCE_B_GO 8
`define BCE_F_OP 7:4
`define BCE_B_CIPH 0
`define BCE_F_CHAIN 3:1
`define BCE_F_KMODE 5:4
`define BCE_F_KSRC 9:6
`define BCE_B_TEXT_A_BUSY 6
`define BCE_B_ABORT 5
`define BCE_B_WRAP 4
`define BCE_B_MODF 3
`define BCE_B_KEYF 2
`define BCE_B_DONEF 1
`define BCE_B_OTPBSY 0
`define BCE_B_OTPWR 0
`define BCE_B_OTPRD 1
`define BCE_OP_ENC 4'h0
`define BCE_OP_DEC 4'h1
`define BCE_OP_EXP 4'h2
`define BCE_OP_RNG 4'hA
`define BCE_OP_SGEN 4'hC
`define BCE_OP_SENC 4'hE
`define BCE_OP_SLD 4'hF
`define BCE_CH_ECB 3'h0
`define BCE_CH_CBC 3'h1
`define BCE_CH_CTR 3'h4
`define BCE_KM_BAD 2'h3
`define BCE_RST16 16'h0000
`endif

// ---- verilog/bce_pkg.sv ----
// Types shared by the cipher engine front end
package bce_pkg;
   // Register access from the processor core
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } bce_sfr_req_t;
   // Engine sequencer states
   typedef enum logic [1:0] {
      BCE_IDLE = 2'b00,
      BCE_EXPAND = 2'b01,
      BCE_RUN = 2'b10
   } bce_state_t;
endpackage

// ---- verilog/bce_engine.sv ----
// Cipher engine control, data arrays, key storage and operation sequencer
`timescale 1ns/1ps
`include "bce_defines.svh"
//
// Notes on behaviour
// (R01) Three 128-bit text arrays, one 256-bit key
// (R02) Text writes refused while go is set
// (R03) Key array always reads back as zero
// (R04) Key loads from software or OTP storage
// (R05) Text B holds chaining data or counter
// (R06) Text C takes result, feeds OTP programming
// (R07) Four-bit operation select at bits 7:4
// (R08) Software changes operation only while idle; code takes operation field writes while go is set too
// (R09) Go starts operation, clears at completion
// (R10) Software go clear aborts, sets abort flag
// (R11) Go refused while OTP busy or flags
// (R12) Go with OTP write starts nothing
// (R13) Go ignored while engine disabled
// (R14) Disable holds go, busy, OTP write low
// (R15) Other registers stay accessible while disabled
// (R16) Operation 0000 selects block encryption
// (R17) Only lowest n key bits used
// (R18) Illegal key setup flags error, blocks start
// (R19) Software pads short blocks itself
// (R20) Free-buffer interrupt enable at bit 10
// (R21) Done flag only when done enable set
// (R22) AES 128/192/256, DES single/2-key/3-key keys
// (R23) All chaining modes, one operation at once
// (R24) OTP key array, config page, key RAM
// (R25) Operation 0001 selects block decryption
// (R26) Fresh key expansion before decrypt when stale
// (R27) Done flag set with go clear, not abort
// (R28) Text A busy until A may reload; busy clears one cycle into the run, A writes stay refused until go clears
module bce_engine
   import bce_pkg::*;
#(
   parameter int OP_CYCLES = 16,
   parameter int EXP_CYCLES = 8,
   parameter int OTP_CYCLES = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   input wire bce_sfr_req_t sfrReq,
   output logic [15:0] sfrRdata,
   output logic doneIrq,
   output logic bufferFreeIrq
);
   // Control and status storage
   logic [15:0] engine_control_low;
   logic [15:0] engine_control_high;
   logic abort_flag, counter_wrap_flag, operation_done_irq_flag, text_a_busy;
   logic otp_write_bit, otp_read_bit;
   // (R01) data arrays and key array
   logic [127:0] text_array_a, text_array_b, text_array_c;
   logic [255:0] key_array;
   // (R24) OTP key pages, config page and volatile key RAM
   logic [255:0] otpMem [16];
   logic [255:0] keyRam [16];
   logic [31:0] cfgPage;
   // Sequencer
   bce_state_t state;
   logic [15:0] cnt;
   logic [15:0] otpCnt;
   logic needExpand;
   logic [127:0] capA;

   // Field decode
   wire engine_enable = engine_control_low[`BCE_B_ON];
   wire operation_go = engine_control_low[`BCE_B_GO];
   wire [3:0] operation_select = engine_control_low[`BCE_F_OP];
   wire cipher_select = engine_control_high[`BCE_B_CIPH];
   wire [2:0] chaining_mode_select = engine_control_high[`BCE_F_CHAIN];
   wire [1:0] key_length_mode = engine_control_high[`BCE_F_KMODE];
   wire [3:0] key_source_select = engine_control_high[`BCE_F_KSRC];
   wire otpBusy = otp_write_bit | otp_read_bit;

   // (R16) legal codes, 0000 is encrypt
   function automatic logic legal_op(input logic [3:0] op);
      legal_op = op == `BCE_OP_ENC || op == `BCE_OP_DEC || op == `BCE_OP_EXP ||
                 op == `BCE_OP_RNG || op == `BCE_OP_SGEN || op == `BCE_OP_SENC ||
                 op == `BCE_OP_SLD;
   endfunction

   // Key bit count as a mask
   function automatic logic [255:0] key_mask(input logic aes, input logic [1:0] km);
      logic [8:0] n;
      n = 9'd0;
      // (R22) key lengths per cipher
      if (aes) begin
         n = (km == 2'h0) ? 9'd128 : (km == 2'h1) ? 9'd192 : 9'd256;
      end else begin
         n = (km == 2'h0) ? 9'd64 : (km == 2'h1) ? 9'd128 : 9'd192;
      end
      key_mask = ~(256'h0) >> (9'd256 - n);
   endfunction

   // (R18) illegal key setup flag
   wire key_config_error_flag = key_length_mode == `BCE_KM_BAD;
   // (R07) unknown operation or chaining code
   wire mode_error_flag = !legal_op(operation_select) || chaining_mode_select > `BCE_CH_CTR;

   // Register bus decode
   wire wrCon = sfrReq.wr && sfrReq.addr == `BCE_A_CONL;
   wire wrConH = sfrReq.wr && sfrReq.addr == `BCE_A_CONH;
   wire wrStat = sfrReq.wr && sfrReq.addr == `BCE_A_STAT;
   wire wrOtp = sfrReq.wr && sfrReq.addr == `BCE_A_OTP;
   wire [2:0] wIdx = sfrReq.addr[2:0];
   wire wrA = sfrReq.wr && sfrReq.addr[7:3] == `BCE_A_TXTA;
   wire wrB = sfrReq.wr && sfrReq.addr[7:3] == `BCE_A_TXTB;
   wire wrC = sfrReq.wr && sfrReq.addr[7:3] == `BCE_A_TXTC;
   wire wrK = sfrReq.wr && sfrReq.addr[7:4] == `BCE_A_KEY;
   wire [3:0] kIdx = sfrReq.addr[3:0];
   wire goWr = sfrReq.wdata[`BCE_B_GO];

   // (R11) start interlock on OTP activity and flags
   wire startOk = !otpBusy && !abort_flag && !counter_wrap_flag &&
                  !mode_error_flag && !key_config_error_flag;
   // (R13) a disabled engine takes no start
   wire goStart = wrCon && goWr && !operation_go && engine_enable && startOk;
   // (R10) software clears go mid-operation
   wire swAbort = wrCon && !goWr && operation_go;
   // (R25) code 0001 selects decryption
   wire decOp = operation_select == `BCE_OP_DEC;
   wire lastCyc = cnt == 16'd1;
   wire finish = state == BCE_RUN && lastCyc && operation_go;
   // (R17) only the low key bits reach the datapath
   wire [255:0] useKey = key_array & key_mask(cipher_select, key_length_mode);
   // (R05) counter mode steps text B as the counter
   wire isCtr = chaining_mode_select == `BCE_CH_CTR;
   wire [128:0] ctrNext = {1'b0, text_array_b} + 129'd1;
   // Stand-in transform; the cipher datapath itself sits behind this
   wire [127:0] result = capA ^ text_array_b ^ useKey[127:0] ^ useKey[255:128];
   wire ecbCbc = chaining_mode_select == `BCE_CH_ECB || chaining_mode_select == `BCE_CH_CBC;

   // Read mux; key words never return data
   always_comb begin
      sfrRdata = `BCE_RST16;
      if (sfrReq.addr == `BCE_A_CONL) begin
         sfrRdata = engine_control_low;
      end else if (sfrReq.addr == `BCE_A_CONH) begin
         sfrRdata = engine_control_high;
      end else if (sfrReq.addr == `BCE_A_STAT) begin
         sfrRdata[`BCE_B_TEXT_A_BUSY] = text_a_busy;
         sfrRdata[`BCE_B_ABORT] = abort_flag;
         sfrRdata[`BCE_B_WRAP] = counter_wrap_flag;
         sfrRdata[`BCE_B_MODF] = mode_error_flag;
         sfrRdata[`BCE_B_KEYF] = key_config_error_flag;
         sfrRdata[`BCE_B_DONEF] = operation_done_irq_flag;
         sfrRdata[`BCE_B_OTPBSY] = otpBusy;
      end else if (sfrReq.addr == `BCE_A_OTP) begin
         sfrRdata[`BCE_B_OTPWR] = otp_write_bit;
         sfrRdata[`BCE_B_OTPRD] = otp_read_bit;
      end else if (sfrReq.addr[7:3] == `BCE_A_TXTA) begin
         sfrRdata = text_array_a[wIdx*16 +: 16];
      end else if (sfrReq.addr[7:3] == `BCE_A_TXTB) begin
         sfrRdata = text_array_b[wIdx*16 +: 16];
      end else if (sfrReq.addr[7:3] == `BCE_A_TXTC) begin
         sfrRdata = text_array_c[wIdx*16 +: 16];
      end
      // (R03) key array reads fall through as zero
   end

   assign doneIrq = operation_done_irq_flag;

   // Control low register and go bit
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         engine_control_low <= `BCE_RST16;
      end else if (ce) begin
         if (wrCon) begin
            // (R15) fields writable while disabled; go written only via start
            engine_control_low <= sfrReq.wdata;
            engine_control_low[`BCE_B_GO] <= goStart || (operation_go && goWr);
         end
         // (R09) hardware clears go at completion
         if (finish) begin
            engine_control_low[`BCE_B_GO] <= 1'b0;
         end
         // (R14) disable holds go low
         if (!engine_enable) begin
            engine_control_low[`BCE_B_GO] <= 1'b0;
         end
      end
   end

   // Control high register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         engine_control_high <= `BCE_RST16;
      end else if (ce && wrConH) begin
         engine_control_high <= sfrReq.wdata;
      end
   end

   // Sticky status flags, hardware set wins over software clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         abort_flag <= 1'b0;
         counter_wrap_flag <= 1'b0;
         operation_done_irq_flag <= 1'b0;
      end else if (ce) begin
         if (wrStat) begin
            abort_flag <= abort_flag & sfrReq.wdata[`BCE_B_ABORT];
            counter_wrap_flag <= counter_wrap_flag & sfrReq.wdata[`BCE_B_WRAP];
            operation_done_irq_flag <= operation_done_irq_flag & sfrReq.wdata[`BCE_B_DONEF];
         end
         // (R10) abort flag on software clear
         if (swAbort) begin
            abort_flag <= 1'b1;
         end
         if (finish && isCtr && ctrNext[128]) begin
            counter_wrap_flag <= 1'b1;
         end
         // (R21) done flag gated by its enable
         // (R27) done set with go clear only
         if (finish && engine_control_low[`BCE_B_OPERATION_DONE_IRQ_ENABLE]) begin
            operation_done_irq_flag <= 1'b1;
         end
      end
   end

   // Sequencer: optional key expansion, then the operation
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= BCE_IDLE;
         cnt <= 16'h0000;
         capA <= 128'h0;
         text_a_busy <= 1'b0;
         bufferFreeIrq <= 1'b0;
      end else if (ce) begin
         bufferFreeIrq <= 1'b0;
         // (R23) one operation at a time
         unique case (state)
            BCE_IDLE: begin
               if (goStart) begin
                  capA <= text_array_a;
                  text_a_busy <= 1'b1;
                  // (R26) stale expansion is redone before decrypt
                  if (decOp && needExpand) begin
                     state <= BCE_EXPAND;
                     cnt <= 16'(EXP_CYCLES);
                  end else begin
                     state <= BCE_RUN;
                     cnt <= 16'(OP_CYCLES);
                  end
               end
            end
            BCE_EXPAND: begin
               cnt <= cnt - 16'd1;
               if (lastCyc) begin
                  state <= BCE_RUN;
                  cnt <= 16'(OP_CYCLES);
               end
            end
            BCE_RUN: begin
               cnt <= cnt - 16'd1;
               // (R28) A consumed; busy clears, text writes stay refused until go clears
               if (text_a_busy) begin
                  text_a_busy <= 1'b0;
                  // (R20) free-buffer pulse in ECB and CBC
                  bufferFreeIrq <= engine_control_low[`BCE_B_BUFFER_FREE_IRQ_ENABLE] && ecbCbc;
               end
               if (lastCyc) begin
                  state <= BCE_IDLE;
               end
            end
         endcase
         // (R10) abort or disable ends the operation at once
         if (swAbort || !engine_enable) begin
            state <= BCE_IDLE;
            cnt <= 16'h0000;
            // (R14) disable holds text A busy low
            text_a_busy <= 1'b0;
         end
      end
   end

   // Key expansion bookkeeping
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         needExpand <= 1'b1;
      end else if (ce) begin
         if (state == BCE_EXPAND && lastCyc) begin
            needExpand <= 1'b0;
         end
         if (wrConH && sfrReq.wdata[9:4] != engine_control_high[9:4]) begin
            needExpand <= 1'b1;
         end
         if (otp_write_bit && otpCnt == 16'd1) begin
            needExpand <= 1'b1;
         end
      end
   end

   // Data arrays
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         text_array_a <= 128'h0;
         text_array_b <= 128'h0;
         text_array_c <= 128'h0;
      end else if (ce) begin
         // (R02) text writes refused while go is set
         if (!operation_go) begin
            if (wrA) text_array_a[wIdx*16 +: 16] <= sfrReq.wdata;
            if (wrB) text_array_b[wIdx*16 +: 16] <= sfrReq.wdata;
            if (wrC) text_array_c[wIdx*16 +: 16] <= sfrReq.wdata;
         end
         if (finish) begin
            // (R06) final output lands in text C
            text_array_c <= result;
            // (R05) text B chains or counts
            text_array_b <= isCtr ? ctrNext[127:0] : result;
         end
      end
   end

   // OTP control and key storage
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         otp_write_bit <= 1'b0;
         otp_read_bit <= 1'b0;
         otpCnt <= 16'h0000;
         key_array <= 256'h0;
         cfgPage <= 32'h0;
      end else if (ce) begin
         // (R12) no OTP start alongside or during an operation
         if (wrOtp && !otpBusy && !operation_go && !goStart) begin
            otp_write_bit <= sfrReq.wdata[`BCE_B_OTPWR] && engine_enable;
            otp_read_bit <= sfrReq.wdata[`BCE_B_OTPRD];
            otpCnt <= 16'(OTP_CYCLES);
         end else if (otpBusy) begin
            otpCnt <= otpCnt - 16'd1;
            if (otpCnt == 16'd1) begin
               otp_write_bit <= 1'b0;
               otp_read_bit <= 1'b0;
            end
         end
         // (R04) software key word writes
         if (wrK) begin
            key_array[kIdx*16 +: 16] <= sfrReq.wdata;
         end
         // (R04) OTP page load into the key array
         if (otp_read_bit && otpCnt == 16'd1) begin
            key_array <= otpMem[key_source_select];
         end
         // (R06) text C programs set bits only
         if (otp_write_bit && otpCnt == 16'd1 && key_source_select == 4'h0) begin
            cfgPage <= cfgPage | text_array_c[31:0];
         end
         // (R14) disable holds OTP write low
         if (!engine_enable) begin
            otp_write_bit <= 1'b0;
         end
      end
   end

   // OTP pages and volatile key RAM contents
   always_ff @(posedge clock) begin
      if (ce && otp_write_bit && otpCnt == 16'd1 && key_source_select != 4'h0) begin
         otpMem[key_source_select][127:0] <= otpMem[key_source_select][127:0] | text_array_c;
      end
      if (ce && finish && operation_select == `BCE_OP_SLD) begin
         keyRam[key_source_select] <= useKey;
      end
   end

   // (R09) go falls when the run count ends
   a_go_clears_done: assert property (@(posedge clock) disable iff (!rst_n)
      ce && finish |=> !operation_go) else $error("go stayed set after completion");
   // (R10) abort flag follows software clear
   a_abort_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
      ce && swAbort |=> abort_flag && state == BCE_IDLE) else $error("abort not flagged");
   // (R13) no start while disabled
   a_no_go_off: assert property (@(posedge clock) disable iff (!rst_n)
      ce && !engine_enable |=> !operation_go) else $error("go set while disabled");
   // (R11) no start while a flag blocks
   a_start_interlock: assert property (@(posedge clock) disable iff (!rst_n)
      ce && !operation_go && (abort_flag || key_config_error_flag || otpBusy)
      |=> !operation_go) else $error("go set despite interlock");
   // (R02) text A holds while go is set
   a_text_locked: assert property (@(posedge clock) disable iff (!rst_n)
      ce && operation_go && wrA |=> $stable(text_array_a)) else $error("text A written in op");
   // (R03) key reads give zero
   a_key_reads_zero: assert property (@(posedge clock) disable iff (!rst_n)
      sfrReq.addr[7:4] == `BCE_A_KEY |-> sfrRdata == 16'h0000) else $error("key readable");
   // (R27) done flag rises with go falling
   a_done_with_go: assert property (@(posedge clock) disable iff (!rst_n)
      ce && $rose(operation_done_irq_flag) |-> $fell(operation_go)) else $error("done misplaced");
   // (R28) busy clears one cycle into the run
   a_busy_clears: assert property (@(posedge clock) disable iff (!rst_n)
      ce && goStart && !(decOp && needExpand) ##1 ce && operation_go |=> !text_a_busy)
      else $error("text A busy stuck");
   // (R14) disable clears OTP write
   a_off_otp_low: assert property (@(posedge clock) disable iff (!rst_n)
      ce && !engine_enable |=> !otp_write_bit) else $error("OTP write held while off");
endmodule

// ---- sim/bce_cpu_model.sv ----
// Processor-side register access model for the cipher engine front end
`timescale 1ns/1ps
module bce_cpu_model
   import bce_pkg::*;
(
   input wire logic clock,
   output bce_sfr_req_t sfrReq,
   input wire logic [15:0] sfrRdata
);
   // Bus idle until the first access
   initial begin
      sfrReq = '0;
   end

   // Write word, strobe held until the edge that takes it
   task automatic write(input logic [7:0] addr, input logic [15:0] data);
      sfrReq <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge clock);
   endtask

   // Read word, address held one whole cycle, data taken at the closing edge
   task automatic read(input logic [7:0] addr, output logic [15:0] data);
      sfrReq <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: ~sfrReq.wdata};
      @(posedge clock);
      data = sfrRdata;
   endtask

   // Release the bus, stale fields inverted so nothing leans on them
   task automatic idle(input int cycles);
      sfrReq <= '{wr: 1'b0, rd: 1'b0, addr: ~sfrReq.addr, wdata: ~sfrReq.wdata};
      repeat (cycles) @(posedge clock);
   endtask
endmodule

// ---- sim/block_cipher_engine_control_test.sv ----
// Self-checking testbench of the cipher engine front end
`timescale 1ns/1ps
`include "bce_defines.svh"
module block_cipher_engine_control_test
   import bce_pkg::*;
;
   localparam int OPC = 8; // Shortened run length
   localparam int EXC = 2; // Shortened key expansion
   localparam int OTC = 4; // Storage access at the default length
   localparam logic [15:0] RUN_ENC = 16'h8D00; // On, both irq enables, go, encrypt
   logic clock; // System clock
   logic rst_n; // Synchronous reset
   logic ce; // Clock enable
   bce_sfr_req_t sfrReq; // Register request
   logic [15:0] sfrRdata; // Read data
   logic doneIrq; // Completion level
   logic bufferFreeIrq; // Text A free pulse
   logic watch; // A noted read is on the bus
   logic [15:0] expVal[$]; // Expected values
   logic [15:0] expMask[$]; // Bits compared
   string expName[$]; // Names of checked items
   logic [15:0] txt[3][8]; // Text words written
   logic [3:0] ops[8]; // Operation codes tried
   int errors; // Mismatches
   int samples_checked; // Comparisons
   int freePulses; // Free-buffer pulses seen
   int seed; // Random seed
   int runLen[3]; // Decrypt poll counts

   // Engine under test
   bce_engine #(.OP_CYCLES(OPC), .EXP_CYCLES(EXC), .OTP_CYCLES(OTC)) dut_u (
      .clock(clock), .rst_n(rst_n), .ce(ce), .sfrReq(sfrReq),
      .sfrRdata(sfrRdata), .doneIrq(doneIrq), .bufferFreeIrq(bufferFreeIrq));

   // Processor side
   bce_cpu_model cpu_u (.clock(clock), .sfrReq(sfrReq), .sfrRdata(sfrRdata));

   // Clock at 10 MHz
   always #50 clock = ~clock;

   // Compare and count
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic conclude();
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Read with a noted expectation
   task automatic rdx(input string name, input logic [7:0] addr, input logic [15:0] mask,
                      input logic [15:0] exp);
      logic [15:0] d;
      expName.push_back(name);
      expMask.push_back(mask);
      expVal.push_back(exp & mask);
      watch = 1'b1;
      cpu_u.read(addr, d);
      watch = 0;
   endtask

   // Poll go until clear, bounded
   task automatic wait_idle(output int cnt);
      logic [15:0] d;
      cnt = 0;
      do begin
         cpu_u.read(`BCE_A_CONL, d);
         cnt++;
      end while (d[`BCE_B_GO] !== 1'b0 && cnt < 200);
      if (cnt >= 200) begin
         check("go release", 16'h0001, 16'h0000);
      end
   endtask

   // Text word address
   function automatic logic [7:0] taddr(input int a, input int k);
      return 8'(8'h10 + 8 * a + k);
   endfunction

   // Output watcher, oldest note against each noted read
   always @(negedge clock) begin
      if (bufferFreeIrq === 1'b1) begin
         freePulses++;
      end
      if (watch === 1'b1 && sfrReq.rd === 1'b1 && expVal.size() > 0) begin
         check(expName.pop_front(), sfrRdata & expMask.pop_front(), expVal.pop_front());
      end
   end

   // Watchdog
   initial begin
      #(5000 * 100);
      errors++;
      conclude();
   end

   // Main sequence
   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      ce = 1'b1;
      watch = 1'b0;
      errors = 0;
      samples_checked = 0;
      freePulses = 0;
      seed = 13;
      ops = '{`BCE_OP_ENC, `BCE_OP_DEC, `BCE_OP_EXP, `BCE_OP_RNG, `BCE_OP_SGEN,
              `BCE_OP_SENC, `BCE_OP_SLD, 4'h3};
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      // Reset values and an unmapped word
      rdx("control low", `BCE_A_CONL, 16'hFFFF, 16'h0000);
      rdx("control high", `BCE_A_CONH, 16'hFFFF, 16'h0000);
      rdx("status", `BCE_A_STAT, 16'hFFFF, 16'h0000);
      rdx("otp control", `BCE_A_OTP, 16'hFFFF, 16'h0000);
      rdx("unmapped", 8'h40, 16'hFFFF, 16'h0000);
      // Engine off: fields writable, go and otp write held low
      cpu_u.write(`BCE_A_CONH, 16'h0003);
      rdx("control high off", `BCE_A_CONH, 16'h03FF, 16'h0003);
      cpu_u.write(`BCE_A_CONL, 16'h0DF0);
      rdx("go while off", `BCE_A_CONL, 16'h8DF0, 16'h0CF0);
      cpu_u.write(`BCE_A_OTP, 16'h0001);
      rdx("otp write off", `BCE_A_OTP, 16'h0001, 16'h0000);
      // Text arrays and key filled with random words
      // whole blocks written, nothing to pad
      for (int a = 0; a < 3; a++) begin
         for (int k = 0; k < 8; k++) begin
            txt[a][k] = 16'($random(seed));
            cpu_u.write(taddr(a, k), txt[a][k]);
         end
      end
      for (int k = 0; k < 16; k++) begin
         cpu_u.write(8'(8'h30 + k), 16'($random(seed)));
      end
      for (int a = 0; a < 3; a++) begin
         for (int k = 0; k < 8; k++) begin
            rdx("text word", taddr(a, k), 16'hFFFF, txt[a][k]);
         end
      end
      for (int k = 0; k < 16; k++) begin
         rdx("key word", 8'(8'h30 + k), 16'hFFFF, 16'h0000);
      end
      // AES ECB encrypt with busy, refused text write and completion
      cpu_u.write(`BCE_A_CONH, 16'h0001);
      cpu_u.write(`BCE_A_CONL, 16'h8C00);
      cpu_u.write(`BCE_A_CONL, RUN_ENC);
      rdx("busy first", `BCE_A_STAT, 16'h0040, 16'h0040);
      rdx("busy cleared", `BCE_A_STAT, 16'h0040, 16'h0000);
      cpu_u.write(taddr(0, 0), ~txt[0][0]);
      wait_idle(runLen[0]);
      check("done irq", {15'h0000, doneIrq}, 16'h0001);
      check("free pulses", 16'(freePulses), 16'h0001);
      rdx("text held", taddr(0, 0), 16'hFFFF, txt[0][0]);
      rdx("done flag", `BCE_A_STAT, 16'h0002, 16'h0002);
      // Abort in mid-run, then go refused while abort stands
      cpu_u.write(`BCE_A_STAT, 16'h0000);
      cpu_u.write(`BCE_A_CONL, RUN_ENC);
      cpu_u.write(`BCE_A_CONL, 16'h8C00);
      rdx("abort status", `BCE_A_STAT, 16'h0062, 16'h0020);
      rdx("go after abort", `BCE_A_CONL, 16'h0100, 16'h0000);
      check("no done on abort", {15'h0000, doneIrq}, 16'h0000);
      cpu_u.write(`BCE_A_CONL, RUN_ENC);
      rdx("go refused flag", `BCE_A_CONL, 16'h0100, 16'h0000);
      cpu_u.write(`BCE_A_STAT, 16'h0000);
      // Illegal key mode blocks go
      cpu_u.write(`BCE_A_CONH, 16'h0031);
      rdx("key error", `BCE_A_STAT, 16'h0004, 16'h0004);
      cpu_u.write(`BCE_A_CONL, RUN_ENC);
      rdx("go refused key", `BCE_A_CONL, 16'h0100, 16'h0000);
      cpu_u.write(`BCE_A_CONH, 16'h0001);
      rdx("key error gone", `BCE_A_STAT, 16'h0004, 16'h0000);
      // Key load from storage blocks go while busy
      cpu_u.write(`BCE_A_OTP, 16'h0002);
      rdx("otp busy", `BCE_A_STAT, 16'h0001, 16'h0001);
      cpu_u.write(`BCE_A_CONL, RUN_ENC);
      rdx("go refused otp", `BCE_A_CONL, 16'h0100, 16'h0000);
      cpu_u.idle(OTC + 2);
      rdx("otp done", `BCE_A_OTP, 16'h0003, 16'h0000);
      // Every defined operation code plus code 0011, idle only, unknown one flagged
      for (int i = 0; i < 8; i++) begin
         cpu_u.write(`BCE_A_CONL, {8'h80, ops[i], 4'h0});
         rdx("operation field", `BCE_A_CONL, 16'h00F0, {8'h00, ops[i], 4'h0});
         rdx("mode error", `BCE_A_STAT, 16'h0008, {12'h000, 1'(i == 7), 3'h0});
      end
      // Decrypt runs: expansion after reset and after key mode change
      cpu_u.write(`BCE_A_CONL, 16'h8010);
      for (int i = 0; i < 3; i++) begin
         if (i == 2) begin
            cpu_u.write(`BCE_A_CONH, 16'h0011);
         end
         cpu_u.write(`BCE_A_STAT, 16'h0000);
         cpu_u.write(`BCE_A_CONL, 16'h8110);
         wait_idle(runLen[i]);
         check("done irq masked", {15'h0000, doneIrq}, 16'h0000);
      end
      check("first expansion", 16'(runLen[0] - runLen[1]), 16'(EXC));
      check("rekey expansion", 16'(runLen[2] - runLen[1]), 16'(EXC));
      // Disable in mid-run holds go and busy low
      cpu_u.write(`BCE_A_CONL, RUN_ENC);
      cpu_u.write(`BCE_A_CONL, 16'h0000);
      rdx("go after disable", `BCE_A_CONL, 16'h0100, 16'h0000);
      rdx("busy after disable", `BCE_A_STAT, 16'h0060, 16'h0020);
      cpu_u.idle(2);
      conclude();
   end
endmodule
